// ===== wiper_link_pkg.sv
// Shared constants of the serial wiper load link and both of its ends
// Summary of operation
// - Eight-bit word per frame, most significant first
// - Select low: sample serial_in each rising clock
// - Select rising copies shift word to wiper
// - Surplus bits push out earliest; last eight kept
// - serial_out repeats previous frame, eight bits late
// - serial_out open drain; pull-up supplied externally
// - Two-device chain: sixteen bits, far first
// - Host holds select low through all bits
// - Host slows serial clock when chained
// - Optional double select pulse for gated updates
// - Wiper code picks one of 256 taps
package wiper_link_pkg;
  localparam int         WORD_BITS      = 8;
  localparam int         CHAIN_BITS     = 16;
  localparam int         TAP_COUNT      = 256;
  localparam logic [7:0] WIPER_RESET    = 8'h00;
  localparam logic [7:0] SHIFT_RESET    = 8'h00;
  localparam int         MCLK_PERIOD_NS = 100;
  localparam int         HALF_FAST_NS   = 200;
  localparam int         HALF_SLOW_NS   = 400;
  localparam int         CS_GAP_NS      = 400;
  localparam logic [3:0] HALF_FAST      = 4'((HALF_FAST_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [3:0] HALF_SLOW      = 4'((HALF_SLOW_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [3:0] CS_GAP         = 4'((CS_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [4:0] BITS_SINGLE    = 5'd8;
  localparam logic [4:0] BITS_CHAIN     = 5'd16;
endpackage

// ===== wiper_link_if.sv
// Four-wire link with open-drain return line
`timescale 1ns/10ps
`default_nettype none
interface wiper_link_if;
  logic cs_n;
  logic sclk;
  logic serial_in;
  logic sdo_o;
  logic sdo_oe;
  wire  serial_out;

  // Released line is held high by the pull-up
  assign serial_out = sdo_oe ? sdo_o : 1'b1;

  modport host (output cs_n, output sclk, output serial_in, input serial_out);
  modport dev  (input cs_n, input sclk, input serial_in, output sdo_o, output sdo_oe);
endinterface
`default_nettype wire

// ===== wiper_dev.sv
// Device end: serial shift register, select-rise load and tap decode
`timescale 1ns/10ps
`default_nettype none
module wiper_dev
  import wiper_link_pkg::*;
(
  input  wire logic         MCLK,    // Core clock
  input  wire logic         RESET,   // Async reset, active high
  wiper_link_if.dev         LINK,    // Serial link pins
  output logic [7:0]        WIPER,   // Wiper code register
  output logic [TAP_COUNT-1:0] TAP,  // One-hot tap select
  output logic              LOADED   // One-cycle pulse per load
);
  typedef struct packed {
    logic [7:0] shift;
  } link_s;

  typedef struct packed {
    logic       cs_s1;
    logic       cs_s2;
    logic       cs_s3;
    logic       cs_level;
    logic [7:0] wiper;
    logic [TAP_COUNT-1:0] tap;
    logic       loaded;
  } core_s;

  link_s lnk;
  link_s next_lnk;
  core_s core;
  core_s next_core;

  // Link side, clocked by the serial clock
  always_comb begin
    next_lnk = lnk;
    if (!LINK.cs_n) begin
      next_lnk.shift = {lnk.shift[WORD_BITS-2:0], LINK.serial_in};
    end
  end

  always_ff @(posedge LINK.sclk or posedge RESET) begin
    if (RESET) begin
      lnk <= '{shift: SHIFT_RESET};
    end else begin
      lnk <= next_lnk;
    end
  end

  // Oldest held bit leaves first; only pulls low
  assign LINK.sdo_o  = 1'b0;
  assign LINK.sdo_oe = ~lnk.shift[WORD_BITS-1];

  // Core side; held word is static while select is high
  always_comb begin
    next_core        = core;
    next_core.cs_s1  = LINK.cs_n;
    next_core.cs_s2  = core.cs_s1;
    next_core.cs_s3  = core.cs_s2;
    next_core.loaded = 1'b0;
    if (core.cs_s2 == core.cs_s3) begin
      next_core.cs_level = core.cs_s3;
      if (core.cs_s3 && !core.cs_level) begin
        next_core.wiper  = lnk.shift;
        next_core.tap    = TAP_COUNT'(1) << lnk.shift;
        next_core.loaded = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      core <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, cs_level: 1'b1,
                wiper: WIPER_RESET, tap: TAP_COUNT'(1) << WIPER_RESET, loaded: 1'b0};
    end else begin
      core <= next_core;
    end
  end

  assign WIPER  = core.wiper;
  assign TAP    = core.tap;
  assign LOADED = core.loaded;
endmodule
`default_nettype wire

// ===== wiper_host.sv
// Host end: frames one or two wiper words onto the link
`timescale 1ns/10ps
`default_nettype none
module wiper_host
  import wiper_link_pkg::*;
(
  input  wire logic        MCLK,    // Core clock
  input  wire logic        RESET,   // Async reset, active high
  wiper_link_if.host       LINK,    // Serial link pins
  input  wire logic        START,   // Begin a frame, pulse
  input  wire logic [15:0] WORD,    // Chain: far in [15:8]; single: [7:0]
  input  wire logic        CHAIN,   // 1: sixteen bits for two devices
  input  wire logic        DOUBLE,  // 1: issue select as two pulses
  output logic             BUSY,    // Frame in progress
  output logic             DONE     // One-cycle pulse at end
);
  typedef enum logic [6:0] {
    IDLE  = 7'b0000001,
    LEAD  = 7'b0000010,
    HIGH  = 7'b0000100,
    LOW   = 7'b0001000,
    TAIL  = 7'b0010000,
    GAP   = 7'b0100000,
    PULSE = 7'b1000000
  } host_e;

  typedef struct packed {
    host_e       state;
    logic [15:0] shift;
    logic [4:0]  bits;
    logic [3:0]  timer;
    logic [3:0]  half;
    logic        dbl;
    logic        second;
    logic        cs_n;
    logic        sclk;
    logic        serial_in;
    logic        done;
  } host_s;

  host_s st;
  host_s next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.timer != 4'h0) begin
      next_st.timer = st.timer - 4'h1;
    end
    unique case (st.state)
      IDLE: begin
        if (START) begin
          next_st.shift  = CHAIN ? WORD : {WORD[7:0], 8'h00};
          next_st.bits   = CHAIN ? BITS_CHAIN : BITS_SINGLE;
          next_st.half   = CHAIN ? HALF_SLOW : HALF_FAST;
          next_st.timer  = (CHAIN ? HALF_SLOW : HALF_FAST) - 4'h1;
          next_st.dbl    = DOUBLE;
          next_st.second = 1'b0;
          next_st.cs_n   = 1'b0;
          next_st.serial_in    = CHAIN ? WORD[15] : WORD[7];
          next_st.state  = LEAD;
        end
      end
      LEAD, LOW: begin
        if (st.timer == 4'h0) begin
          next_st.sclk  = 1'b1;
          next_st.timer = st.half - 4'h1;
          next_st.state = HIGH;
        end
      end
      HIGH: begin
        if (st.timer == 4'h0) begin
          next_st.sclk  = 1'b0;
          next_st.timer = st.half - 4'h1;
          next_st.bits  = st.bits - 5'd1;
          if (st.bits == 5'd1) begin
            next_st.state = TAIL;
          end else begin
            next_st.shift = {st.shift[14:0], 1'b0};
            next_st.serial_in   = st.shift[14];
            next_st.state = LOW;
          end
        end
      end
      TAIL: begin
        if (st.timer == 4'h0) begin
          next_st.cs_n  = 1'b1;
          next_st.timer = CS_GAP - 4'h1;
          next_st.state = GAP;
        end
      end
      GAP: begin
        if (st.timer == 4'h0) begin
          if (st.dbl && !st.second) begin
            next_st.second = 1'b1;
            next_st.cs_n   = 1'b0;
            next_st.timer  = CS_GAP - 4'h1;
            next_st.state  = PULSE;
          end else begin
            next_st.done  = 1'b1;
            next_st.state = IDLE;
          end
        end
      end
      PULSE: begin
        if (st.timer == 4'h0) begin
          next_st.cs_n  = 1'b1;
          next_st.timer = CS_GAP - 4'h1;
          next_st.state = GAP;
        end
      end
      default: begin
        next_st.state = IDLE;
        next_st.cs_n  = 1'b1;
        next_st.sclk  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      st <= '{state: IDLE, shift: 16'h0000, bits: 5'd0, timer: 4'h0, half: 4'h0,
              dbl: 1'b0, second: 1'b0, cs_n: 1'b1, sclk: 1'b0, serial_in: 1'b0, done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign LINK.cs_n = st.cs_n;
  assign LINK.sclk = st.sclk;
  assign LINK.serial_in  = st.serial_in;
  assign BUSY      = (st.state != IDLE);
  assign DONE      = st.done;
endmodule
`default_nettype wire

// ===== wiper_link_asserts.sv
// Link protocol checker for the serial wiper load link
`timescale 1ns/10ps
`default_nettype none
module wiper_link_asserts (
  input wire logic MCLK,   // Core clock
  input wire logic RESET,  // Async reset
  input wire logic cs_n,   // Select, active low
  input wire logic sclk,   // Serial clock
  input wire logic serial_in,    // Serial data
  input wire logic sdo_o,  // Drive value
  input wire logic sdo_oe, // Pull-low enable
  input wire logic serial_out     // Resolved return line
);
  logic       sclk_q;
  logic [4:0] edges;
  // Rising serial edges seen in this frame
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sclk_q <= 1'b0;
      edges  <= 5'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        edges <= 5'h00;
      end else if (sclk && !sclk_q) begin
        edges <= edges + 5'h01;
      end
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_frame_bits: assert property ($rose(cs_n) |-> edges inside {5'h00, 5'h08, 5'h10})
    else $error("frame ended on a bad bit count");
  a_chain_cap: assert property (edges <= 5'h10)
    else $error("more than sixteen bits in a frame");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_data_steady: assert property (sclk |-> $stable(serial_in))
    else $error("data moved while clock high");
  a_high_phase: assert property ($rose(sclk) |-> sclk[*2])
    else $error("clock high phase too short");
  a_low_phase: assert property ($fell(sclk) |-> (!sclk)[*2])
    else $error("clock low phase too short");
  a_od_low: assert property (sdo_oe |-> !sdo_o)
    else $error("return line driven high");
  a_pull_up: assert property (!sdo_oe |-> serial_out)
    else $error("released line not high");
  a_gap_hold: assert property ($rose(cs_n) |-> cs_n[*4])
    else $error("select gap too short");
  a_shift_frozen: assert property (cs_n |-> $stable(sdo_oe))
    else $error("shift word moved while select high");
endmodule
`default_nettype wire

// ===== tb.sv
// Bench: host end driving two chained device ends
`timescale 1ns/10ps
`default_nettype none
module tb;
  import wiper_link_pkg::*;
  logic                 mclk, reset, start, chain, dbl, busy, done, loaded1;
  logic [15:0]          word;
  logic [7:0]           wiper1, wiper2;
  logic [TAP_COUNT-1:0] tap1, tap2;
  int                   n_errors, comparisons, cycles, loads, load_base;
  wiper_link_if lk1();
  wiper_link_if lk2();
  assign lk2.cs_n = lk1.cs_n;
  assign lk2.sclk = lk1.sclk;
  assign lk2.serial_in  = lk1.serial_out;
  wiper_host u_wiper_host (.MCLK(mclk), .RESET(reset), .LINK(lk1.host), .START(start), .WORD(word),
    .CHAIN(chain), .DOUBLE(dbl), .BUSY(busy), .DONE(done));
  wiper_dev u_wiper_dev (.MCLK(mclk), .RESET(reset), .LINK(lk1.dev), .WIPER(wiper1), .TAP(tap1),
    .LOADED(loaded1));
  wiper_dev u_wiper_dev_far (.MCLK(mclk), .RESET(reset), .LINK(lk2.dev), .WIPER(wiper2), .TAP(tap2),
    .LOADED());
  wiper_link_asserts u_wiper_link_asserts (.MCLK(mclk), .RESET(reset), .cs_n(lk1.cs_n),
    .sclk(lk1.sclk), .serial_in(lk1.serial_in), .sdo_o(lk1.sdo_o), .sdo_oe(lk1.sdo_oe), .serial_out(lk1.serial_out));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (loaded1 === 1'b1) loads <= loads + 1;
    if (cycles == 2000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_tap(input logic [TAP_COUNT-1:0] got, input logic [7:0] idx);
    comparisons++;
    if (got !== (TAP_COUNT'(1) << idx)) begin
      n_errors++;
      $display("wrong value at %0t: tap not at %h", $time, idx);
    end
  endtask
  // One host command, then time for the device load to land
  task automatic send(input logic [15:0] w, input logic ch, input logic db);
    int waited;
    int expect_cycles;
    expect_cycles = 1 + (2 * (ch ? CHAIN_BITS : WORD_BITS) + 1) * int'(ch ? HALF_SLOW : HALF_FAST)
                    + int'(CS_GAP) * (db ? 3 : 1);
    @(negedge mclk);
    word      = w;
    chain     = ch;
    dbl       = db;
    start     = 1'b1;
    load_base = loads;
    @(negedge mclk);
    start  = 1'b0;
    waited = 1;
    chk8({7'h00, busy}, 8'h01);
    while (done !== 1'b1) begin
      @(negedge mclk);
      waited++;
    end
    chk8({7'h00, busy}, 8'h00);
    chk8(8'(waited), 8'(expect_cycles));
    repeat (8) @(negedge mclk);
  endtask
  // Start held high while busy must not begin a second frame
  task automatic refused_start();
    int base;
    base = loads;
    @(negedge mclk);
    word  = 16'h0081;
    chain = 1'b0;
    dbl   = 1'b0;
    start = 1'b1;
    @(negedge mclk);
    word = 16'h00FF;
    repeat (4) @(negedge mclk);
    start = 1'b0;
    while (done !== 1'b1) @(negedge mclk);
    repeat (12) @(negedge mclk);
    chk8(wiper1, 8'h81);
    chk8(wiper2, 8'h5A);
    chk8({7'h00, busy}, 8'h00);
    chk8(8'(loads - base), 8'h01);
  endtask
  // Reset in mid-run returns both ends to idle values
  task automatic reset_again();
    @(negedge mclk);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    check_reset();
    chk8(wiper2, WIPER_RESET);
    send(16'h0042, 1'b0, 1'b0);
    chk8(wiper1, 8'h42);
    chk8(wiper2, 8'h00);
  endtask
  task automatic check_reset();
    chk8(wiper1, WIPER_RESET);
    chk_tap(tap1, 8'h00);
    chk8({7'h00, lk1.serial_out}, 8'h00);
  endtask
  task automatic single_pair();
    send(16'h00A5, 1'b0, 1'b0);
    chk8(wiper1, 8'hA5);
    chk_tap(tap1, 8'hA5);
    chk8(wiper2, 8'h00);
    chk8(8'(loads - load_base), 8'h01);
    send(16'h003C, 1'b0, 1'b0);
    chk8(wiper1, 8'h3C);
    chk8(wiper2, 8'hA5);
    chk8({7'h00, lk2.serial_out}, 8'h01);
  endtask
  task automatic chain_split();
    send(16'hC396, 1'b1, 1'b0);
    chk8(wiper2, 8'hC3);
    chk_tap(tap2, 8'hC3);
    chk8(wiper1, 8'h96);
  endtask
  task automatic double_pulse();
    send(16'h005A, 1'b0, 1'b1);
    chk8(wiper1, 8'h5A);
    chk8(wiper2, 8'h96);
    chk8(8'(loads - load_base), 8'h02);
  endtask
  initial begin
    reset = 1'b1;
    start = 1'b0;
    word  = 16'h0000;
    chain = 1'b0;
    dbl   = 1'b0;
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    check_reset();
    single_pair();
    chain_split();
    double_pulse();
    refused_start();
    reset_again();
    tally_and_finish();
  end
endmodule
`default_nettype wire
